// ---- src/bridge_driver_pwm_spi_switch.sv ----
/*
  serial / voltage pwm output switch for an external bridge driver,
  with ahb-lite register slave and a level interrupt.
  assumes ramp velocity, table values and serial engine pins come from
  neighbouring blocks on the same clock.
*/
`include "pwm_switch_cfg.svh"
module bridge_driver_pwm_spi_switch (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic signed [31:0] RAMP_VELOCITY_IN,
  input wire logic [9:0] TABLE_POS_IN,
  input wire logic [8:0] SINE_VALUE_IN,
  input wire logic [8:0] COSINE_VALUE_IN,
  output logic [9:0] TABLE_POS_OUT,
  input wire logic SER_CLK_IN,
  input wire logic SER_DATA_IN,
  input wire logic SER_SELECT_N_IN,
  output logic [7:0] SER_STATUS_OUT,
  input wire logic DRIVER_SERIAL_DATA_PIN_IN,
  output logic DRIVER_SERIAL_DATA_PIN_OUT,
  output logic DRIVER_SELECT_PIN_OUT,
  output logic DRIVER_SERIAL_CLOCK_PIN_OUT,
  output logic MULTIPURPOSE_OUT_TWO_OUT,
  output logic PWM_MODE_OUT,
  output logic IRQ_OUT
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] global_config_q;
  logic [31:0] mode_switch_velocity_q;
  logic [31:0] pwm_period_cycles_q;
  logic [7:0] lookup_offset_q;
  logic [`STATUS_WIDTH-1:0] status_q;
  logic [`STATUS_WIDTH-1:0] irq_enable_q;
  logic [`STATUS_WIDTH-1:0] clear_pulse;
  logic [7:0] ser_status_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  logic take;
  assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take && HWRITE_IN;
      rd_pend_q <= take && !HWRITE_IN;
      if (take) begin
        // word index, since several offsets are not multiples of four
        addr_q <= HADDR_IN[9:2];
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      global_config_q <= `RESET_WORD;
      mode_switch_velocity_q <= `RESET_WORD;
      pwm_period_cycles_q <= `RESET_PERIOD;
      lookup_offset_q <= 8'h00;
      irq_enable_q <= '0;
    end else if (wr_pend_q) begin
      unique case (addr_q)
        `ADDR_GLOBAL_CONFIG: global_config_q <= HWDATA_IN;
        `ADDR_MODE_SWITCH_VEL: mode_switch_velocity_q <= HWDATA_IN;
        `ADDR_PWM_PERIOD: pwm_period_cycles_q <= HWDATA_IN;
        `ADDR_LOOKUP_OFFSET: lookup_offset_q <= HWDATA_IN[7:0];
        `ADDR_IRQ_ENABLE: irq_enable_q <= HWDATA_IN[`STATUS_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  assign clear_pulse = (wr_pend_q && addr_q == `ADDR_IRQ_CLEAR) ? HWDATA_IN[`STATUS_WIDTH-1:0] : '0;

  logic [15:0] scale_q;
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      HRDATA_OUT <= `RESET_WORD;
    end else if (take && !HWRITE_IN) begin
      unique case (HADDR_IN[9:2])
        `ADDR_GLOBAL_CONFIG: HRDATA_OUT <= global_config_q;
        `ADDR_MODE_SWITCH_VEL: HRDATA_OUT <= mode_switch_velocity_q;
        `ADDR_PWM_PERIOD: HRDATA_OUT <= pwm_period_cycles_q;
        `ADDR_STATUS: HRDATA_OUT <= {28'h0000000, status_q};
        `ADDR_IRQ_ENABLE: HRDATA_OUT <= {28'h0000000, irq_enable_q};
        `ADDR_PWM_SCALE: HRDATA_OUT <= {16'h0000, scale_q};
        // write-only offset and clear read as zero, like unmapped words
        default: HRDATA_OUT <= `RESET_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode selection
  logic [3:0] proto;
  logic proto_ok;
  logic volt_en;
  logic [31:0] abs_vel;
  pwm_switch_pkg::out_mode_e mode_q;
  pwm_switch_pkg::out_mode_e mode_d;
  assign proto = global_config_q[`PROTO_MSB:`PROTO_LSB];
  assign proto_ok = (proto == `PROTO_FAMILY_ONE) || (proto == `PROTO_FAMILY_TWO);
  assign volt_en = global_config_q[`BIT_VOLT_EN];
  assign abs_vel = RAMP_VELOCITY_IN[31] ? 32'(-RAMP_VELOCITY_IN) : RAMP_VELOCITY_IN;

  always_comb begin
    mode_d = pwm_switch_pkg::MODE_SERIAL;
    if (volt_en && proto_ok) begin
      if (mode_switch_velocity_q == `RESET_WORD) begin
        mode_d = pwm_switch_pkg::MODE_PWM;
      end else if (abs_vel < mode_switch_velocity_q) begin
        mode_d = pwm_switch_pkg::MODE_PWM;
      end else begin
        mode_d = pwm_switch_pkg::MODE_SERIAL;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      mode_q <= pwm_switch_pkg::MODE_SERIAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  logic in_pwm;
  assign in_pwm = (mode_q == pwm_switch_pkg::MODE_PWM);

  ////////////////////////////////////////////////////////////////////////
  // period counter and duty
  logic [31:0] count_q;
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      count_q <= `RESET_WORD;
    end else if (count_q + 32'h1 >= pwm_period_cycles_q) begin
      count_q <= `RESET_WORD;
    end else begin
      count_q <= count_q + 32'h1;
    end
  end

  assign TABLE_POS_OUT = in_pwm ? 10'((TABLE_POS_IN + {2'b00, lookup_offset_q}) & `TABLE_MASK) : TABLE_POS_IN;

  // scale grows linearly with speed, saturating; scale enable bit
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      scale_q <= 16'hffff;
    end else if (!global_config_q[`BIT_SCALE_EN]) begin
      scale_q <= 16'hffff;
    end else if (abs_vel[31:16] != 16'h0000) begin
      scale_q <= 16'hffff;
    end else begin
      scale_q <= abs_vel[15:0];
    end
  end

  // duty = period/2 + value*scale*period/2^25, value signed 9 bit
  function automatic logic [31:0] duty_of(input logic signed [8:0] v, input logic [15:0] s,
                                          input logic [31:0] p);
    logic signed [63:0] prod;
    prod = 64'(v) * $signed({1'b0, s}) * $signed({1'b0, p});
    return 32'((p >> 1) + 32'(prod >>> 25));
  endfunction

  logic [31:0] duty_a;
  logic [31:0] duty_b;
  logic pwm_a;
  logic pwm_b;
  // sine to a, cosine to b
  assign duty_a = duty_of(SINE_VALUE_IN, scale_q, pwm_period_cycles_q);
  assign duty_b = duty_of(COSINE_VALUE_IN, scale_q, pwm_period_cycles_q);

  pwm_phase_gen phase_a (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .period_in(pwm_period_cycles_q),
    .count_in(count_q),
    .duty_in(duty_a),
    .pwm_out(pwm_a)
  );
  pwm_phase_gen phase_b (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .period_in(pwm_period_cycles_q),
    .count_in(count_q),
    .duty_in(duty_b),
    .pwm_out(pwm_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // pins, all registered so a mode change cannot glitch them
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      DRIVER_SERIAL_DATA_PIN_OUT <= 1'b0;
      DRIVER_SELECT_PIN_OUT <= 1'b1;
      DRIVER_SERIAL_CLOCK_PIN_OUT <= 1'b1;
      MULTIPURPOSE_OUT_TWO_OUT <= 1'b1;
      PWM_MODE_OUT <= 1'b0;
    end else if (in_pwm) begin
      DRIVER_SERIAL_DATA_PIN_OUT <= pwm_a;
      DRIVER_SELECT_PIN_OUT <= pwm_b;
      DRIVER_SERIAL_CLOCK_PIN_OUT <= 1'b1;
      MULTIPURPOSE_OUT_TWO_OUT <= 1'b0;
      PWM_MODE_OUT <= 1'b1;
    end else begin
      DRIVER_SERIAL_DATA_PIN_OUT <= SER_DATA_IN;
      DRIVER_SELECT_PIN_OUT <= SER_SELECT_N_IN;
      DRIVER_SERIAL_CLOCK_PIN_OUT <= SER_CLK_IN;
      MULTIPURPOSE_OUT_TWO_OUT <= 1'b1;
      PWM_MODE_OUT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // driver error line and status
  logic [`STATUS_WIDTH-1:0] event_set;
  logic mode_chg;
  assign mode_chg = (mode_d != mode_q);
  // error line sets three fault bits
  assign event_set = {mode_chg,
                      {`ERR_FRAME_LEN{in_pwm && DRIVER_SERIAL_DATA_PIN_IN}}};

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      ser_status_q <= 8'h00;
    end else if (in_pwm) begin
      ser_status_q[`ST_OVC_A] <= DRIVER_SERIAL_DATA_PIN_IN;
      ser_status_q[`ST_OVC_B] <= DRIVER_SERIAL_DATA_PIN_IN;
      ser_status_q[`ST_OVTEMP] <= DRIVER_SERIAL_DATA_PIN_IN;
    end
  end
  assign SER_STATUS_OUT = ser_status_q;

  // set wins over a simultaneous clear
  genvar gi;
  generate
    for (gi = 0; gi < `STATUS_WIDTH; gi++) begin : g_status
      always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
          status_q[gi] <= 1'b0;
        end else if (event_set[gi]) begin
          status_q[gi] <= 1'b1;
        end else if (clear_pulse[gi]) begin
          status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign IRQ_OUT = |(status_q & irq_enable_q);
endmodule

// ---- src/pwm_phase_gen.sv ----
/*
  one pwm phase: counter compare against a duty word.
  assumes period is held stable by the caller between updates.
*/
`include "pwm_switch_cfg.svh"
module pwm_phase_gen (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] period_in,
  input wire logic [31:0] count_in,
  input wire logic [31:0] duty_in,
  output logic pwm_out
);
  // duty compared against the shared counter; registered to avoid glitches
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (period_in != `RESET_WORD) && (count_in < duty_in);
    end
  end
endmodule

// ---- src/pwm_switch_cfg.svh ----
/*
  constants of the bridge driver pwm / serial switch block.
  assumes inclusion by bare name from the design and bench files.
*/
// What this block does
// - each pwm period lasts pwm_period_cycles system clocks.
// - protocol codes 1000 and 1001 route pwm onto the driver serial pins.
// - voltage enable set with zero switch velocity gives pwm, serial off.
// - pwm mode drives coil a onto data pin, coil b onto select pin.
// - pwm mode drives multipurpose output two low.
// - pwm mode samples error line, updates three bridge fault status bits.
// - pwm mode holds driver serial clock pin high.
// - voltage enable cleared restores serial output, output two high.
// - auto switching picks pwm while absolute velocity below switch velocity.
// - auto switching picks serial while absolute velocity at or above it.
// - during pwm only, lookup value shifted by write-only offset 0 to 255.
// - coil a duty follows sine, coil b duty follows cosine.
// - pwm amplitude scales linearly with ramp velocity when enabled.
`ifndef PWM_SWITCH_CFG_SVH
`define PWM_SWITCH_CFG_SVH
// register indices; byte address is four times the index
`define ADDR_GLOBAL_CONFIG 8'h00
`define ADDR_MODE_SWITCH_VEL 8'h1d
`define ADDR_PWM_PERIOD 8'h1f
`define ADDR_LOOKUP_OFFSET 8'h79
`define ADDR_STATUS 8'h80
`define ADDR_IRQ_CLEAR 8'h84
`define ADDR_IRQ_ENABLE 8'h88
`define ADDR_PWM_SCALE 8'h8c
`define BIT_VOLT_EN 21
`define BIT_SCALE_EN 8
`define PROTO_LSB 0
`define PROTO_MSB 3
`define PROTO_FAMILY_ONE 4'h8
`define PROTO_FAMILY_TWO 4'h9
`define RESET_WORD 32'h0000_0000
`define RESET_PERIOD 32'h0000_0100
`define STATUS_WIDTH 4
`define ST_OVC_A 0
`define ST_OVC_B 1
`define ST_OVTEMP 2
`define ST_MODE_CHG 3
`define ERR_FRAME_LEN 3
`define TABLE_MASK 10'h3ff
`define QUARTER_TURN 10'h100
`define HTRANS_NONSEQ 2'b10
`define HSIZE_WORD 3'b010
`endif

// ---- src/pwm_switch_pkg.sv ----
/*
  types of the bridge driver pwm / serial switch block.
  assumes the cfg header is on the include path.
*/
package pwm_switch_pkg;
  typedef enum logic [1:0] {MODE_SERIAL, MODE_PWM} out_mode_e;
  typedef logic [31:0] word_t;
endpackage

// ---- verif/bridge_driver_model.sv ----
/*
  behavioural bridge driver on the shared serial / pwm pins.
  assumes pin levels change on the controller clock.
*/
module bridge_driver_model (
  input wire logic clk_in,
  input wire logic fault_in,
  input wire logic data_pin_in,
  input wire logic select_n_in,
  input wire logic serial_mode_in,
  output logic err_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bridge_a_mode_input;
  logic last_q = 1'b0;
  assign bridge_a_mode_input = 1'b1;
  // released line toggles so a stale value never reads as valid
  always @(posedge clk_in) begin
    if (!serial_mode_in)
      last_q <= fault_in & bridge_a_mode_input;
    else if (!select_n_in)
      last_q <= data_pin_in;
    else
      last_q <= ~last_q;
  end
  assign err_out = last_q;
endmodule

// ---- verif/pwm_switch_props.sv ----
/*
  checker for the mode pins, fault sampling and table offset.
  assumes it is bound to the switch top module, one clock domain.
*/
module pwm_switch_props (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [9:0] TABLE_POS_IN,
  input wire logic [9:0] TABLE_POS_OUT,
  input wire logic SER_DATA_IN,
  input wire logic [7:0] SER_STATUS_OUT,
  input wire logic DRIVER_SERIAL_DATA_PIN_IN,
  input wire logic DRIVER_SERIAL_DATA_PIN_OUT,
  input wire logic DRIVER_SERIAL_CLOCK_PIN_OUT,
  input wire logic MULTIPURPOSE_OUT_TWO_OUT,
  input wire logic PWM_MODE_OUT
);
  default clocking @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // two cycles so a pin stage behind the mode flop is covered
  sequence pwm_steady;
    PWM_MODE_OUT ##1 PWM_MODE_OUT;
  endsequence
  sequence ser_steady;
    !PWM_MODE_OUT ##1 !PWM_MODE_OUT;
  endsequence
  ////////////////////////////////////////
  out_two_low_a: assert property (pwm_steady |-> !MULTIPURPOSE_OUT_TWO_OUT)
    else $error("output two not low in pwm mode");
  clock_pin_high_a: assert property (pwm_steady |-> DRIVER_SERIAL_CLOCK_PIN_OUT)
    else $error("clock pin not high in pwm mode");
  out_two_high_a: assert property (ser_steady |-> MULTIPURPOSE_OUT_TWO_OUT)
    else $error("output two not high in serial mode");
  serial_forward_a: assert property (ser_steady |-> DRIVER_SERIAL_DATA_PIN_OUT == $past(SER_DATA_IN))
    else $error("serial data not forwarded");
  fault_sample_a: assert property (pwm_steady ##0 DRIVER_SERIAL_DATA_PIN_IN |-> ##[1:4] SER_STATUS_OUT[2:0] == 3'b111)
    else $error("error line not sampled");
  table_pass_a: assert property (ser_steady |-> $past(TABLE_POS_OUT) == $past(TABLE_POS_IN))
    else $error("table offset applied in serial mode");
  mode_rise_a: assert property ($rose(PWM_MODE_OUT) |-> ##[0:1] !MULTIPURPOSE_OUT_TWO_OUT)
    else $error("output two late on entering pwm");
  mode_fall_a: assert property ($fell(PWM_MODE_OUT) |-> ##[0:1] MULTIPURPOSE_OUT_TWO_OUT)
    else $error("output two late on leaving pwm");
endmodule
////////////////////////////////////////
bind bridge_driver_pwm_spi_switch pwm_switch_props pwm_switch_props_inst (
  .CORE_CLK_IN, .RST_N_IN, .TABLE_POS_IN, .TABLE_POS_OUT, .SER_DATA_IN, .SER_STATUS_OUT,
  .DRIVER_SERIAL_DATA_PIN_IN, .DRIVER_SERIAL_DATA_PIN_OUT, .DRIVER_SERIAL_CLOCK_PIN_OUT,
  .MULTIPURPOSE_OUT_TWO_OUT, .PWM_MODE_OUT
);

// ---- verif/tb_top.sv ----
/*
  bench: ahb-lite register tasks, protocol, fault and auto switch tests.
  assumes design, checker and driver model are compiled before it.
*/
`include "pwm_switch_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic signed [31:0] vel = 32'sh0;
  logic [9:0] tpos = 10'h005;
  logic ser = 1'b0;
  logic fault = 1'b0;
  logic hready, hresp, err, dpin, spin, cpin, two, pwm, irq;
  logic [31:0] hrdata, r;
  logic [9:0] tpos_o;
  logic [7:0] st;
  int err_total = 0;
  int comparisons = 0;
  logic [3:0] codes [3] = '{4'h3, `PROTO_FAMILY_ONE, `PROTO_FAMILY_TWO};
  int vels [5] = '{-50, 99, 100, -100, -99};
  logic ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  always #20 clk = ~clk;
  always @(posedge clk) ser <= ~ser;
  bridge_driver_pwm_spi_switch bridge_driver_pwm_spi_switch_inst (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(`HSIZE_WORD), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .RAMP_VELOCITY_IN(vel),
    .TABLE_POS_IN(tpos), .SINE_VALUE_IN(9'h000), .COSINE_VALUE_IN(9'h000), .TABLE_POS_OUT(tpos_o),
    .SER_CLK_IN(ser), .SER_DATA_IN(~ser), .SER_SELECT_N_IN(ser), .SER_STATUS_OUT(st),
    .DRIVER_SERIAL_DATA_PIN_IN(err), .DRIVER_SERIAL_DATA_PIN_OUT(dpin), .DRIVER_SELECT_PIN_OUT(spin),
    .DRIVER_SERIAL_CLOCK_PIN_OUT(cpin), .MULTIPURPOSE_OUT_TWO_OUT(two), .PWM_MODE_OUT(pwm),
    .IRQ_OUT(irq)
  );
  bridge_driver_model bridge_driver_model_inst (
    .clk_in(clk), .fault_in(fault), .data_pin_in(dpin), .select_n_in(spin),
    .serial_mode_in(two), .err_out(err)
  );
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one extra edge at the end lets register updates land
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a << 2;
    hwrite <= w;
    htrans <= `HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(r, e);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  task automatic measure(input logic sel_b, input int exp);
    int t0, p, c;
    logic prev, now;
    t0 = -1;
    p = -1;
    prev = 1'b1;
    for (c = 0; c < 200; c++) begin
      @(posedge clk);
      now = sel_b ? spin : dpin;
      if (now === 1'b1 && prev === 1'b0) begin
        if (t0 < 0)
          t0 = c;
        else if (p < 0)
          p = c - t0;
      end
      prev = now;
    end
    check(p, exp);
  endtask
  task automatic results;
    $display("counts: %0d compares, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    check({31'h0, two}, 32'h1);
    rdc(`ADDR_GLOBAL_CONFIG, `RESET_WORD);
    rdc(`ADDR_PWM_PERIOD, `RESET_PERIOD);
    rdc(`ADDR_STATUS, 32'h0);
    rdc(32'h40, 32'h0);
    check({31'h0, hresp}, 32'h0);
    rdc(`ADDR_PWM_SCALE, 32'h0000ffff);
    $display("test reset done");
    ahb(1'b1, `ADDR_PWM_PERIOD, 32'd20);
    ahb(1'b1, `ADDR_LOOKUP_OFFSET, 32'd255);
    vel <= 32'sd5000;
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, `ADDR_GLOBAL_CONFIG, (32'h1 << `BIT_VOLT_EN) | codes[i]);
      settle();
      check({31'h0, pwm}, {31'h0, i > 0});
    end
    check({30'h0, two, cpin}, 32'h1);
    check({22'h0, tpos_o}, 32'h104);
    measure(1'b0, 20);
    measure(1'b1, 20);
    $display("test pwm pins done");
    fault <= 1'b1;
    settle();
    ahb(1'b0, `ADDR_STATUS, 32'h0);
    check(r & 32'h7, 32'h7);
    check({24'h0, st} & 32'h7, 32'h7);
    ahb(1'b1, `ADDR_IRQ_ENABLE, 32'h7);
    check({31'h0, irq}, 32'h1);
    ahb(1'b1, `ADDR_IRQ_ENABLE, 32'h0);
    check({31'h0, irq}, 32'h0);
    fault <= 1'b0;
    settle();
    ahb(1'b1, `ADDR_IRQ_CLEAR, 32'hf);
    rdc(`ADDR_STATUS, 32'h0);
    ahb(1'b1, `ADDR_IRQ_ENABLE, 32'hf);
    check({31'h0, irq}, 32'h0);
    $display("test fault irq done");
    ahb(1'b1, `ADDR_MODE_SWITCH_VEL, 32'd100);
    for (int i = 0; i < 5; i++) begin
      vel <= vels[i];
      settle();
      check({31'h0, pwm}, {31'h0, ex[i]});
    end
    $display("test auto switch done");
    vel <= 32'sd0;
    ahb(1'b1, `ADDR_GLOBAL_CONFIG, {28'h0, `PROTO_FAMILY_ONE});
    settle();
    check({30'h0, two, pwm}, 32'h2);
    check({22'h0, tpos_o}, 32'h5);
    $display("test serial restore done");
    vel <= -32'sh1234;
    ahb(1'b1, `ADDR_GLOBAL_CONFIG, (32'h1 << `BIT_SCALE_EN) | `PROTO_FAMILY_ONE);
    settle();
    rdc(`ADDR_PWM_SCALE, 32'h0000_1234);
    vel <= 32'sh0002_0000;
    settle();
    rdc(`ADDR_PWM_SCALE, 32'h0000_ffff);
    $display("test scale done");
    results();
  end
  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule
